// file: mlr_pkg.sv
// Package: opcodes, carriers and register map of the execution datapath
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
package mlr_pkg;

  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 8;
  localparam int FLG_W   = 4;
  localparam int PADDR_W = 12;
  localparam int PDATA_W = 32;

  localparam logic [PADDR_W-1:0] REG_CTRL   = 12'h000;
  localparam logic [PADDR_W-1:0] REG_ACC    = 12'h004;
  localparam logic [PADDR_W-1:0] REG_FLAGS  = 12'h008;
  localparam logic [PADDR_W-1:0] REG_STATUS = 12'h00c;

  localparam int CTRL_EN_BIT = 0;
  localparam int FLG_GIE_BIT = 4;
  localparam int STS_ST_LSB  = 0;
  localparam int STS_CNT_LSB = 8;

  localparam logic              CTRL_EN_RST = 1'b1;
  localparam logic              GIE_RST     = 1'b0;
  localparam logic [DATA_W-1:0] ACC_RST     = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_B      = 8'h00;
  localparam logic [DATA_W-1:0] ONE_B       = 8'h01;

  typedef enum logic [4:0] {
    OP_IDLE, OP_COPY_MEM_ACC, OP_COPY_IMM_ACC, OP_COPY_ACC_MEM,
    OP_OR_MEM, OP_OR_IMM, OP_OR_TO_MEM,
    OP_POP_PC, OP_POP_PC_IMM, OP_IRQ_EXIT,
    OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_ACC,
    OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_THRU_CARRY_TO_ACC,
    OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_ACC,
    OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC,
    OP_SUB_WITH_BORROW, OP_SUB_BORROW_TO_MEM,
    OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_TO_ACC
  } mlr_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOAD  = 2'b01,
    ST_EXEC  = 2'b11,
    ST_DUMMY = 2'b10
  } mlr_state_t;

  typedef enum logic [2:0] {
    RG_NONE, RG_CTRL, RG_ACC, RG_FLAGS, RG_STATUS
  } mlr_reg_t;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } mlr_flags_t;

  typedef struct packed {
    mlr_op_t             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   imm;
  } mlr_instr_t;

  typedef struct packed {
    logic wr_acc;
    logic wr_mem;
    logic pop;
    logic skip;
    logic gie_set;
    logic adv_pc;
  } mlr_ctl_t;

  localparam mlr_flags_t FLG_RST = '0;

endpackage : mlr_pkg

// file: mlr_rst_sync.sv
// Reset release synchroniser: asynchronous assert, two-flop release
`timescale 1ns/1ps
module mlr_rst_sync (
  input  logic clk,
  input  logic arst_n,
  output logic srst_n
);

  logic meta_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b0;
      srst_n <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      srst_n <= meta_r;
    end
  end

endmodule : mlr_rst_sync

// file: mlr_alu.sv
// Result, flag and sequencing decode for one instruction
`timescale 1ns/1ps
module mlr_alu
  import mlr_pkg::*;
(
  input  mlr_op_t             op,
  input  logic [DATA_W-1:0]   acc,
  input  logic [DATA_W-1:0]   mdat,
  input  logic [DATA_W-1:0]   imm,
  input  mlr_flags_t          flg_in,
  output logic [DATA_W-1:0]   res,
  output mlr_flags_t          flg_out,
  output mlr_ctl_t            ctl
);

  function automatic logic [DATA_W-1:0] rot(
    input logic [DATA_W-1:0] d,
    input logic              left,
    input logic              fill
  );
    rot = left ? {d[DATA_W-2:0], fill} : {fill, d[DATA_W-1:1]};
  endfunction : rot

  logic [DATA_W:0] sub_sum;
  logic [4:0]      sub_half;

  // Borrow is the inverted carry: acc + ~m + c
  assign sub_sum  = {1'b0, acc} + {1'b0, ~mdat} + {8'h00, flg_in.c};
  assign sub_half = {1'b0, acc[3:0]} + {1'b0, ~mdat[3:0]} + {4'h0, flg_in.c};

  always_comb begin
    res        = mdat;
    flg_out    = flg_in;
    ctl        = '0;
    ctl.adv_pc = 1'b1;
    case (op)
      OP_IDLE:         res = ZERO_B;
      OP_COPY_MEM_ACC: ctl.wr_acc = 1'b1;
      OP_COPY_IMM_ACC: begin
        res        = imm;
        ctl.wr_acc = 1'b1;
      end
      OP_COPY_ACC_MEM: begin
        res        = acc;
        ctl.wr_mem = 1'b1;
      end
      OP_OR_MEM, OP_OR_IMM: begin
        res        = acc | ((op == OP_OR_IMM) ? imm : mdat);
        flg_out.z  = ~|res;
        ctl.wr_acc = 1'b1;
      end
      OP_OR_TO_MEM: begin
        res        = acc | mdat;
        flg_out.z  = ~|res;
        ctl.wr_mem = 1'b1;
      end
      OP_POP_PC, OP_POP_PC_IMM, OP_IRQ_EXIT: begin
        res         = imm;
        ctl.pop     = 1'b1;
        ctl.adv_pc  = 1'b0;
        ctl.wr_acc  = (op == OP_POP_PC_IMM);
        ctl.gie_set = (op == OP_IRQ_EXIT);
      end
      OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_ACC: begin
        res        = rot(mdat, 1'b1, mdat[DATA_W-1]);
        ctl.wr_mem = (op == OP_ROTATE_LEFT);
        ctl.wr_acc = (op == OP_ROTATE_LEFT_TO_ACC);
      end
      OP_ROTATE_LEFT_THRU_CARRY, OP_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
        res        = rot(mdat, 1'b1, flg_in.c);
        flg_out.c  = mdat[DATA_W-1];
        ctl.wr_mem = (op == OP_ROTATE_LEFT_THRU_CARRY);
        ctl.wr_acc = (op == OP_ROTATE_LEFT_THRU_CARRY_TO_ACC);
      end
      OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_ACC: begin
        res        = rot(mdat, 1'b0, mdat[0]);
        ctl.wr_mem = (op == OP_ROTATE_RIGHT);
        ctl.wr_acc = (op == OP_ROTATE_RIGHT_TO_ACC);
      end
      OP_ROTATE_RIGHT_THRU_CARRY, OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC: begin
        res        = rot(mdat, 1'b0, flg_in.c);
        flg_out.c  = mdat[0];
        ctl.wr_mem = (op == OP_ROTATE_RIGHT_THRU_CARRY);
        ctl.wr_acc = (op == OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC);
      end
      OP_SUB_WITH_BORROW, OP_SUB_BORROW_TO_MEM: begin
        res        = sub_sum[DATA_W-1:0];
        flg_out.c  = sub_sum[DATA_W];
        flg_out.ac = sub_half[4];
        flg_out.z  = ~|res;
        flg_out.ov = (acc[DATA_W-1] == ~mdat[DATA_W-1]) &&
                     (res[DATA_W-1] != acc[DATA_W-1]);
        ctl.wr_mem = (op == OP_SUB_BORROW_TO_MEM);
        ctl.wr_acc = (op == OP_SUB_WITH_BORROW);
      end
      OP_DEC_SKIP_ZERO, OP_DEC_SKIP_ZERO_TO_ACC: begin
        res        = mdat - ONE_B;
        ctl.skip   = (res == ZERO_B);
        ctl.wr_mem = (op == OP_DEC_SKIP_ZERO);
        ctl.wr_acc = (op == OP_DEC_SKIP_ZERO_TO_ACC);
      end
      default:         res = ZERO_B;
    endcase
  end

endmodule : mlr_alu

// file: mlr_exec_top.sv
// Execution datapath top: sequencer, accumulator, flags, APB registers
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module mlr_exec_top
  import mlr_pkg::*;
#(
  parameter int RETIRE_W = 8
)(
  input  logic                ref_clk,
  input  logic                resetn,
  input  logic                instr_valid,
  input  mlr_instr_t          instr,
  output logic                instr_ready,
  output logic [ADDR_W-1:0]   mem_addr,
  output logic                mem_rd,
  input  logic [DATA_W-1:0]   mem_rdata,
  output logic                mem_we,
  output logic [DATA_W-1:0]   mem_wdata,
  output logic                pc_inc,
  output logic                stack_pop,
  output logic                fetch_discard,
  output logic [DATA_W-1:0]   acc,
  output mlr_flags_t          flags,
  output logic                global_irq_enable,
  input  logic                psel,
  input  logic                penable,
  input  logic                pwrite,
  input  logic [PADDR_W-1:0]  paddr,
  input  logic [PDATA_W-1:0]  pwdata,
  output logic [PDATA_W-1:0]  prdata,
  output logic                pready,
  output logic                pslverr
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (RETIRE_W < 1 || RETIRE_W > PDATA_W - STS_CNT_LSB) begin : g_chk
    $error("RETIRE_W must fit the status word");
  end

  // ---------------------------------------------------------------
  // Reset and shared decode
  // ---------------------------------------------------------------
  logic rst_n;

  mlr_rst_sync u_rst (
    .clk    (ref_clk),
    .arst_n (resetn),
    .srst_n (rst_n)
  );

  function automatic mlr_reg_t reg_dec(input logic [PADDR_W-1:0] a);
    case (a)
      REG_CTRL:   reg_dec = RG_CTRL;
      REG_ACC:    reg_dec = RG_ACC;
      REG_FLAGS:  reg_dec = RG_FLAGS;
      REG_STATUS: reg_dec = RG_STATUS;
      default:    reg_dec = RG_NONE;
    endcase
  endfunction : reg_dec

  mlr_state_t          state_r;
  mlr_state_t          state_nxt;
  mlr_instr_t          instr_r;
  logic                instr_ready_r;
  logic [ADDR_W-1:0]   mem_addr_r;
  logic                mem_rd_r;
  logic                mem_we_r;
  logic [DATA_W-1:0]   mem_wdata_r;
  logic                pc_inc_r;
  logic                stack_pop_r;
  logic                fetch_discard_r;
  logic [DATA_W-1:0]   acc_r;
  mlr_flags_t          flags_r;
  logic                gie_r;
  logic                ctrl_en_r;
  logic [RETIRE_W-1:0] cnt_r;
  logic [PDATA_W-1:0]  prdata_r;
  logic                pready_r;
  logic                pslverr_r;

  logic                take;
  logic                exec;
  logic                two_cyc;
  logic                apb_setup;
  logic                apb_wr;
  mlr_reg_t            sel_reg;
  logic [PDATA_W-1:0]  rd_word;
  logic [DATA_W-1:0]   alu_res;
  mlr_flags_t          alu_flg;
  mlr_ctl_t            alu_ctl;

  assign take      = instr_valid & instr_ready_r;
  assign exec      = (state_r == ST_EXEC);
  assign two_cyc   = alu_ctl.pop | alu_ctl.skip;
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite & pready_r;
  assign sel_reg   = reg_dec(paddr);

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  // Memory data is only meaningful in the execute state
  mlr_alu u_alu (
    .op      (instr_r.op),
    .acc     (acc_r),
    .mdat    (mem_rdata),
    .imm     (instr_r.imm),
    .flg_in  (flags_r),
    .res     (alu_res),
    .flg_out (alu_flg),
    .ctl     (alu_ctl)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:  state_nxt = take ? ST_LOAD : ST_IDLE;
      ST_LOAD:  state_nxt = ST_EXEC;
      ST_EXEC:  state_nxt = two_cyc ? ST_DUMMY : ST_IDLE;
      ST_DUMMY: state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Ready is registered from the next state, so it is already high in the first idle cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_ready_r <= 1'b0;
    end else begin
      instr_ready_r <= (state_nxt == ST_IDLE) & ctrl_en_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_r    <= '0;
      mem_addr_r <= '0;
      mem_rd_r   <= 1'b0;
    end else begin
      mem_rd_r <= take;
      if (take) begin
        instr_r    <= instr;
        mem_addr_r <= instr.addr;
      end
    end
  end

  // ---------------------------------------------------------------
  // Memory write, fetch and stack strobes
  // ---------------------------------------------------------------
  // Write lands after the read of the same slot, so no hazard arises
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_we_r    <= 1'b0;
      mem_wdata_r <= ZERO_B;
    end else begin
      mem_we_r <= exec & alu_ctl.wr_mem;
      if (exec & alu_ctl.wr_mem) begin
        mem_wdata_r <= alu_res;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_inc_r        <= 1'b0;
      stack_pop_r     <= 1'b0;
      fetch_discard_r <= 1'b0;
    end else begin
      // Skip: second advance steps over the discarded instruction
      pc_inc_r        <= (exec & alu_ctl.adv_pc) |
                         ((state_r == ST_DUMMY) & fetch_discard_r);
      stack_pop_r     <= exec & alu_ctl.pop;
      fetch_discard_r <= exec & alu_ctl.skip;
    end
  end

  // ---------------------------------------------------------------
  // Architectural state
  // ---------------------------------------------------------------
  // Execution wins over a software write in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= ACC_RST;
    end else if (exec & alu_ctl.wr_acc) begin
      acc_r <= alu_res;
    end else if (apb_wr && sel_reg == RG_ACC) begin
      acc_r <= pwdata[DATA_W-1:0];
    end
  end

  // Unaffected flags pass through the ALU unchanged
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= FLG_RST;
    end else if (exec) begin
      flags_r <= alu_flg;
    end else if (apb_wr && sel_reg == RG_FLAGS) begin
      flags_r <= pwdata[FLG_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_r <= GIE_RST;
    end else if (exec & alu_ctl.gie_set) begin
      gie_r <= 1'b1;
    end else if (apb_wr && sel_reg == RG_FLAGS) begin
      gie_r <= pwdata[FLG_GIE_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_r <= CTRL_EN_RST;
    end else if (apb_wr && sel_reg == RG_CTRL) begin
      ctrl_en_r <= pwdata[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (exec) begin
      cnt_r <= cnt_r + RETIRE_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Read data is captured in setup; no wait states are inserted
  always_comb begin
    rd_word = '0;
    case (sel_reg)
      RG_CTRL:   rd_word[CTRL_EN_BIT] = ctrl_en_r;
      RG_ACC:    rd_word[DATA_W-1:0] = acc_r;
      RG_FLAGS: begin
        rd_word[FLG_W-1:0]  = flags_r;
        rd_word[FLG_GIE_BIT] = gie_r;
      end
      RG_STATUS: begin
        rd_word[STS_ST_LSB +: $bits(mlr_state_t)] = state_r;
        rd_word[STS_CNT_LSB +: RETIRE_W] = cnt_r;
      end
      default:   rd_word = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup & (sel_reg == RG_NONE);
      if (apb_setup) begin
        prdata_r <= pwrite ? '0 : rd_word;
      end
    end
  end

  assign instr_ready       = instr_ready_r;
  assign mem_addr          = mem_addr_r;
  assign mem_rd            = mem_rd_r;
  assign mem_we            = mem_we_r;
  assign mem_wdata         = mem_wdata_r;
  assign pc_inc            = pc_inc_r;
  assign stack_pop         = stack_pop_r;
  assign fetch_discard     = fetch_discard_r;
  assign acc               = acc_r;
  assign flags             = flags_r;
  assign global_irq_enable = gie_r;
  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_copy_mem_acc: assert property (
    exec && instr_r.op == OP_COPY_MEM_ACC |=>
      acc_r == $past(mem_rdata) && flags_r == $past(flags_r))
    else $error("memory copy to accumulator wrong");
  a_copy_imm_acc: assert property (
    exec && instr_r.op == OP_COPY_IMM_ACC |=>
      acc_r == $past(instr_r.imm) && flags_r == $past(flags_r))
    else $error("immediate load wrong");
  a_copy_acc_mem: assert property (
    exec && instr_r.op == OP_COPY_ACC_MEM |=>
      mem_we_r && mem_wdata_r == $past(acc_r) && flags_r == $past(flags_r))
    else $error("accumulator store wrong");
  a_idle_advance: assert property (
    exec && instr_r.op == OP_IDLE |=>
      pc_inc_r && !mem_we_r && !stack_pop_r && flags_r == $past(flags_r))
    else $error("idle op had side effects");
  a_or_acc_zero: assert property (
    exec && instr_r.op == OP_OR_MEM |=>
      acc_r == ($past(acc_r) | $past(mem_rdata)) &&
      flags_r.z == (acc_r == ZERO_B) && flags_r.c == $past(flags_r.c))
    else $error("or to accumulator wrong");
  a_or_to_mem: assert property (
    exec && instr_r.op == OP_OR_TO_MEM |=>
      mem_we_r && mem_wdata_r == ($past(acc_r) | $past(mem_rdata)) &&
      flags_r.z == (mem_wdata_r == ZERO_B) && acc_r == $past(acc_r))
    else $error("or to memory wrong");
  a_pop_two_cycles: assert property (
    exec && instr_r.op == OP_POP_PC |=>
      stack_pop_r && !pc_inc_r && state_r == ST_DUMMY
      ##1 state_r == ST_IDLE && !stack_pop_r)
    else $error("return not two cycles");
  a_pop_imm_acc: assert property (
    exec && instr_r.op == OP_POP_PC_IMM |=>
      stack_pop_r && acc_r == $past(instr_r.imm) &&
      flags_r == $past(flags_r))
    else $error("return with immediate wrong");
  a_irq_exit_gie: assert property (
    exec && instr_r.op == OP_IRQ_EXIT |=> stack_pop_r && gie_r)
    else $error("interrupt return left enable clear");
  a_rotate_left: assert property (
    exec && instr_r.op == OP_ROTATE_LEFT |=>
      mem_wdata_r == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} &&
      flags_r == $past(flags_r))
    else $error("rotate left wrong");
  a_rotate_left_c: assert property (
    exec && instr_r.op == OP_ROTATE_LEFT_THRU_CARRY_TO_ACC |=>
      acc_r == {$past(mem_rdata[6:0]), $past(flags_r.c)} &&
      flags_r.c == $past(mem_rdata[7]) && flags_r.z == $past(flags_r.z))
    else $error("rotate left through carry wrong");
  a_rotate_right: assert property (
    exec && instr_r.op == OP_ROTATE_RIGHT_TO_ACC |=>
      acc_r == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} &&
      flags_r == $past(flags_r))
    else $error("rotate right wrong");
  a_rotate_right_c: assert property (
    exec && instr_r.op == OP_ROTATE_RIGHT_THRU_CARRY |=>
      mem_wdata_r == {$past(flags_r.c), $past(mem_rdata[7:1])} &&
      flags_r.c == $past(mem_rdata[0]) && flags_r.ov == $past(flags_r.ov))
    else $error("rotate right through carry wrong");
  a_acc_no_mem: assert property (
    exec && alu_ctl.wr_acc |=> !mem_we_r)
    else $error("accumulator variant wrote memory");
  a_sub_borrow: assert property (
    exec && instr_r.op == OP_SUB_WITH_BORROW |=>
      {flags_r.c, acc_r} == ({1'b0, $past(acc_r)} +
      {1'b0, ~$past(mem_rdata)} + 9'($past(flags_r.c))))
    else $error("subtract with borrow wrong");
  a_sub_to_mem: assert property (
    exec && instr_r.op == OP_SUB_BORROW_TO_MEM |=>
      mem_we_r && acc_r == $past(acc_r) &&
      flags_r.z == (mem_wdata_r == ZERO_B))
    else $error("subtract to memory wrong");
  a_dec_skip: assert property (
    exec && instr_r.op == OP_DEC_SKIP_ZERO |=>
      mem_wdata_r == DATA_W'($past(mem_rdata) - ONE_B) &&
      fetch_discard_r == ($past(mem_rdata) == ONE_B) &&
      flags_r == $past(flags_r))
    else $error("decrement and skip wrong");
  a_skip_dummy: assert property (
    fetch_discard_r |-> state_r == ST_DUMMY ##1 pc_inc_r && state_r == ST_IDLE)
    else $error("skip did not add one dummy cycle");
  a_single_cycle: assert property (
    exec && !two_cyc |=> state_r == ST_IDLE && pc_inc_r && !fetch_discard_r)
    else $error("plain instruction not single cycle");

  c_skip_taken:   cover property (fetch_discard_r);
  c_irq_exit:     cover property (exec && instr_r.op == OP_IRQ_EXIT);
  c_sub_overflow: cover property (exec && alu_flg.ov && !flags_r.ov);
  c_back_to_back: cover property (take ##3 take);

endmodule : mlr_exec_top

// file: mlr_mem_model.sv
// Data memory model: one-cycle synchronous read, strobed write
`timescale 1ns/1ps
module mlr_mem_model
  import mlr_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_rd,
  output logic      [DATA_W-1:0] mem_rdata,
  input  wire logic              mem_we,
  input  wire logic [DATA_W-1:0] mem_wdata
);
  logic [DATA_W-1:0] mem [256];

  initial mem_rdata = 8'h00;

  // Outside the read slot the bus flips every cycle, so a late sample shows
  always @(posedge ref_clk) begin
    if (mem_rd)
      mem_rdata <= mem[mem_addr];
    else
      mem_rdata <= ~mem_rdata;
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
  end
endmodule : mlr_mem_model

// file: testbench.sv
// Self-checking testbench of the execution datapath
`timescale 1ns/1ps
module testbench
  import mlr_pkg::*;
;
  logic              ref_clk, resetn, instr_valid, instr_ready, mem_rd;
  logic              mem_we, pc_inc, stack_pop, fetch_discard, pready;
  logic              global_irq_enable, psel, penable, pwrite, pslverr, e;
  mlr_instr_t        instr;
  logic [7:0]        mem_addr, mem_rdata, mem_wdata, acc;
  mlr_flags_t        flags;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, r;
  int                miscompares, num_checks;

  mlr_exec_top DUT (
    .ref_clk(ref_clk), .resetn(resetn), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .pc_inc(pc_inc), .stack_pop(stack_pop),
    .fetch_discard(fetch_discard), .acc(acc), .flags(flags),
    .global_irq_enable(global_irq_enable), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  mlr_mem_model mdl (
    .ref_clk(ref_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_rdata(mem_rdata), .mem_we(mem_we), .mem_wdata(mem_wdata)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic cmp(logic [31:0] g, logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask : cmp

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // k: 0 single cycle, 1 skip taken, 2 return
  task automatic t(mlr_op_t o, logic [7:0] im, m, ea, logic [3:0] ef,
                   logic [7:0] em, int k);
    int np, no, nd, cy;
    mdl.mem[8'h40] = m;
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr       <= {o, 8'h40, im};
    #1;
    while (instr_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    np = 0;
    no = 0;
    nd = 0;
    for (cy = 1; cy < 9; cy++) begin
      #1;
      np += pc_inc;
      no += stack_pop;
      nd += fetch_discard;
      if (instr_ready === 1'b1) break;
      @(posedge ref_clk);
    end
    // Memory write lands one edge after the results show
    @(posedge ref_clk);
    #1;
    cmp(acc, ea);
    cmp(flags, ef);
    cmp(mdl.mem[8'h40], em);
    cmp(np, k == 1 ? 2 : int'(k == 0));
    cmp(no, k == 2);
    cmp(nd, k == 1);
    cmp(cy, k != 0 ? 4 : 3);
  endtask : t

  initial begin
    #50us;
    miscompares++;
    conclude();
  end

  initial begin
    {resetn, instr_valid, psel, penable, pwrite, paddr, pwdata} = '0;
    instr = '0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    apb(1'b1, REG_FLAGS, 32'h1);
    apb(1'b0, REG_FLAGS, 32'h0);
    cmp(r, 32'h1);
    t(OP_COPY_IMM_ACC, 8'h5a, 8'h00, 8'h5a, 4'h1, 8'h00, 0);
    t(OP_COPY_ACC_MEM, 8'h00, 8'h11, 8'h5a, 4'h1, 8'h5a, 0);
    t(OP_COPY_MEM_ACC, 8'h00, 8'h3c, 8'h3c, 4'h1, 8'h3c, 0);
    t(OP_IDLE, 8'hff, 8'h77, 8'h3c, 4'h1, 8'h77, 0);
    t(OP_COPY_IMM_ACC, 8'h00, 8'h00, 8'h00, 4'h1, 8'h00, 0);
    t(OP_OR_MEM, 8'h00, 8'h00, 8'h00, 4'h5, 8'h00, 0);
    t(OP_OR_IMM, 8'h81, 8'h00, 8'h81, 4'h1, 8'h00, 0);
    t(OP_OR_TO_MEM, 8'h00, 8'h00, 8'h81, 4'h1, 8'h81, 0);
    t(OP_ROTATE_LEFT, 8'h00, 8'h81, 8'h81, 4'h1, 8'h03, 0);
    t(OP_ROTATE_LEFT_TO_ACC, 8'h00, 8'h81, 8'h03, 4'h1, 8'h81, 0);
    t(OP_ROTATE_LEFT_THRU_CARRY, 8'h00, 8'h80, 8'h03, 4'h1, 8'h01,
      0);
    t(OP_ROTATE_LEFT_THRU_CARRY_TO_ACC, 8'h00, 8'h41, 8'h83, 4'h0, 8'h41,
      0);
    t(OP_ROTATE_RIGHT, 8'h00, 8'h01, 8'h83, 4'h0, 8'h80, 0);
    t(OP_ROTATE_RIGHT_TO_ACC, 8'h00, 8'h02, 8'h01, 4'h0, 8'h02, 0);
    t(OP_ROTATE_RIGHT_THRU_CARRY, 8'h00, 8'h01, 8'h01, 4'h1, 8'h00,
      0);
    t(OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC, 8'h00, 8'h00, 8'h80, 4'h0, 8'h00,
      0);
    t(OP_COPY_IMM_ACC, 8'h10, 8'h00, 8'h10, 4'h0, 8'h00, 0);
    t(OP_SUB_WITH_BORROW, 8'h00, 8'h01, 8'h0e, 4'h1, 8'h01, 0);
    t(OP_SUB_BORROW_TO_MEM, 8'h00, 8'h0e, 8'h0e, 4'h7, 8'h00, 0);
    t(OP_COPY_IMM_ACC, 8'h80, 8'h00, 8'h80, 4'h7, 8'h00, 0);
    t(OP_SUB_WITH_BORROW, 8'h00, 8'h01, 8'h7f, 4'h9, 8'h01, 0);
    t(OP_DEC_SKIP_ZERO, 8'h00, 8'h01, 8'h7f, 4'h9, 8'h00, 1);
    t(OP_DEC_SKIP_ZERO_TO_ACC, 8'h00, 8'h05, 8'h04, 4'h9, 8'h05, 0);
    t(OP_DEC_SKIP_ZERO_TO_ACC, 8'h00, 8'h01, 8'h00, 4'h9, 8'h01, 1);
    t(OP_POP_PC, 8'h00, 8'h00, 8'h00, 4'h9, 8'h00, 2);
    t(OP_POP_PC_IMM, 8'ha5, 8'h00, 8'ha5, 4'h9, 8'h00, 2);
    cmp(global_irq_enable, 32'h0);
    t(OP_IRQ_EXIT, 8'h00, 8'h00, 8'ha5, 4'h9, 8'h00, 2);
    cmp(global_irq_enable, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    cmp({r, e}, 33'h1);
    apb(1'b1, REG_ACC, 32'h33);
    apb(1'b0, REG_ACC, 32'h0);
    cmp(r, 32'h33);
    apb(1'b1, REG_CTRL, 32'h0);
    @(posedge ref_clk);
    #1;
    cmp(instr_ready, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    cmp(r, 32'h1b00);
    conclude();
  end
endmodule : testbench
